// ===== hdl/adcreg_bank.sv
// Summary of operation
// - A set test-pattern bit replaces every conversion word with 0xA5A5.
// - The append selector adds nothing, the channel id, or status flags; 11b is reserved.
// - The serial mode field picks clock polarity and phase, and the host must match it.
// - Averaging ratio 000b is off and codes 001b to 111b average 2 to 128 samples.
// - Oscillator select 0 picks the high-speed oscillator and 1 the low-power one.
// - A four-bit divider sets sampling speed while averaging, resetting to 0100b.
// - Each channel function bit makes its channel analog at 0 or digital pin at 1.
// - Each direction bit makes its digital pin an input at 0 or an output at 1.
// - Each drive-type bit makes its output open-drain at 0 or push-pull at 1.
// - Each output level bit sets the level driven on its digital output.
// - The input level register is read-only and shows the sampled pin levels.
// - The force-analog bit makes all channels analog, overriding function and direction.
// - A software reset write returns all writable registers here to defaults and reads back 0.
`default_nettype none
module adcreg_bank
  import adcreg_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Register access port
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [adcreg_pkg::ADDR_W-1:0] addr_i,
  input wire logic [adcreg_pkg::DATA_W-1:0] wdata_i,
  output logic [adcreg_pkg::DATA_W-1:0] rdata_o,
  // Controls from the general configuration
  input wire logic soft_reset_i,
  input wire logic force_analog_channels_i,
  // Conversion data path
  input wire logic [adcreg_pkg::CONV_W-1:0] conv_data_i,
  input wire logic [adcreg_pkg::TAG_W-1:0] manual_channel_number_i,
  input wire logic [adcreg_pkg::TAG_W-1:0] status_flags_i,
  output logic [adcreg_pkg::CONV_W-1:0] out_data_o,
  output logic [adcreg_pkg::TAG_W-1:0] out_tag_o,
  output logic out_tag_valid_o,
  // Timing controls
  output logic [1:0] serial_mode_select_o,
  output logic [2:0] averaging_ratio_o,
  output logic [7:0] average_count_o,
  output logic oscillator_select_o,
  output logic [3:0] clock_divider_o,
  // Channel pins
  output logic [adcreg_pkg::CHAN_N-1:0] analog_channel_o,
  input wire logic [adcreg_pkg::CHAN_N-1:0] pin_i,
  output logic [adcreg_pkg::CHAN_N-1:0] pin_o,
  output logic [adcreg_pkg::CHAN_N-1:0] pin_oe_o
);
  import adcreg_pkg::*;

  logic [7:0] data_format_config_reg, data_format_config_next;
  logic [7:0] averaging_ratio_config_reg, averaging_ratio_config_next;
  logic [7:0] oscillator_timing_config_reg, oscillator_timing_config_next;
  logic [7:0] channel_function_select_reg, channel_function_select_next;
  logic [7:0] digital_pin_direction_reg, digital_pin_direction_next;
  logic [7:0] output_drive_type_reg, output_drive_type_next;
  logic [7:0] output_level_reg, output_level_next;
  logic [7:0] pin_meta_reg, input_level_bits_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic [15:0] out_data_reg, out_data_next;
  logic [3:0] out_tag_reg, out_tag_next;
  logic out_tag_valid_reg, out_tag_valid_next;
  logic [7:0] digital_pin;
  logic [7:0] drive_enable;

  // Write decode for one register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Register writes; soft reset has priority over a write in the same cycle
  always_comb
  begin
    data_format_config_next = data_format_config_reg;
    averaging_ratio_config_next = averaging_ratio_config_reg;
    oscillator_timing_config_next = oscillator_timing_config_reg;
    channel_function_select_next = channel_function_select_reg;
    digital_pin_direction_next = digital_pin_direction_reg;
    output_drive_type_next = output_drive_type_reg;
    output_level_next = output_level_reg;
    if (soft_reset_i)
    begin
      data_format_config_next = DATA_FORMAT_CONFIG_RST;
      averaging_ratio_config_next = AVERAGING_RATIO_CONFIG_RST;
      oscillator_timing_config_next = OSCILLATOR_TIMING_CONFIG_RST;
      channel_function_select_next = PIN_CFG_RST;
      digital_pin_direction_next = PIN_CFG_RST;
      output_drive_type_next = PIN_CFG_RST;
      output_level_next = PIN_CFG_RST;
    end
    else if (wr_en_i)
    begin
      if (hit(addr_i, DATA_FORMAT_CONFIG_ADDR))
        data_format_config_next = wdata_i & DATA_FORMAT_MASK;
      if (hit(addr_i, AVERAGING_RATIO_CONFIG_ADDR))
        averaging_ratio_config_next = wdata_i & AVERAGING_MASK;
      if (hit(addr_i, OSCILLATOR_TIMING_CONFIG_ADDR))
        oscillator_timing_config_next = wdata_i & OSC_TIMING_MASK;
      if (hit(addr_i, CHANNEL_FUNCTION_SELECT_ADDR))
        channel_function_select_next = wdata_i;
      if (hit(addr_i, DIGITAL_PIN_DIRECTION_ADDR))
        digital_pin_direction_next = wdata_i;
      if (hit(addr_i, OUTPUT_DRIVE_TYPE_ADDR))
        output_drive_type_next = wdata_i;
      if (hit(addr_i, OUTPUT_LEVEL_ADDR))
        output_level_next = wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      data_format_config_reg <= DATA_FORMAT_CONFIG_RST;
      averaging_ratio_config_reg <= AVERAGING_RATIO_CONFIG_RST;
      oscillator_timing_config_reg <= OSCILLATOR_TIMING_CONFIG_RST;
      channel_function_select_reg <= PIN_CFG_RST;
      digital_pin_direction_reg <= PIN_CFG_RST;
      output_drive_type_reg <= PIN_CFG_RST;
      output_level_reg <= PIN_CFG_RST;
    end
    else
    begin
      data_format_config_reg <= data_format_config_next;
      averaging_ratio_config_reg <= averaging_ratio_config_next;
      oscillator_timing_config_reg <= oscillator_timing_config_next;
      channel_function_select_reg <= channel_function_select_next;
      digital_pin_direction_reg <= digital_pin_direction_next;
      output_drive_type_reg <= output_drive_type_next;
      output_level_reg <= output_level_next;
    end
  end

  // Pin input synchroniser; pins are asynchronous to the clock
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_meta_reg <= 8'h00;
      input_level_bits_reg <= 8'h00;
    end
    else
    begin
      pin_meta_reg <= pin_i;
      input_level_bits_reg <= pin_meta_reg;
    end
  end

  // Read mux, registered so data appears the cycle after rd_en_i
  always_comb
  begin
    rdata_next = rdata_reg;
    if (rd_en_i)
    begin
      unique case (addr_i)
        DATA_FORMAT_CONFIG_ADDR: rdata_next = data_format_config_reg;
        AVERAGING_RATIO_CONFIG_ADDR: rdata_next = averaging_ratio_config_reg;
        OSCILLATOR_TIMING_CONFIG_ADDR: rdata_next = oscillator_timing_config_reg;
        CHANNEL_FUNCTION_SELECT_ADDR: rdata_next = channel_function_select_reg;
        DIGITAL_PIN_DIRECTION_ADDR: rdata_next = digital_pin_direction_reg;
        OUTPUT_DRIVE_TYPE_ADDR: rdata_next = output_drive_type_reg;
        OUTPUT_LEVEL_ADDR: rdata_next = output_level_reg;
        INPUT_LEVEL_READBACK_ADDR: rdata_next = input_level_bits_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Conversion word formatting
  always_comb
  begin
    if (data_format_config_reg[TEST_PATTERN_BIT])
      out_data_next = TEST_PATTERN_WORD;
    else
      out_data_next = conv_data_i;
    unique case (data_format_config_reg[APPEND_LSB +: 2])
      APPEND_CHAN_ID:
      begin
        out_tag_next = manual_channel_number_i;
        out_tag_valid_next = 1'b1;
      end
      APPEND_STATUS:
      begin
        out_tag_next = status_flags_i;
        out_tag_valid_next = 1'b1;
      end
      default:
      begin
        out_tag_next = 4'h0;
        out_tag_valid_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_reg <= 8'h00;
      out_data_reg <= 16'h0000;
      out_tag_reg <= 4'h0;
      out_tag_valid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      out_data_reg <= out_data_next;
      out_tag_reg <= out_tag_next;
      out_tag_valid_reg <= out_tag_valid_next;
    end
  end

  // Channel roles; force-analog overrides everything
  always_comb
  begin
    digital_pin = force_analog_channels_i ? 8'h00 : channel_function_select_reg;
    analog_channel_o = ~digital_pin;
    drive_enable = digital_pin & digital_pin_direction_reg;
  end

  // Output stage; open-drain releases the pin for a high level
  always_comb
  begin
    pin_o = output_level_reg;
    // open-drain drives only low, inputs never driven
    pin_oe_o = drive_enable & (output_drive_type_reg | ~output_level_reg);
  end

  // Register outputs
  assign rdata_o = rdata_reg;
  assign out_data_o = out_data_reg;
  assign out_tag_o = out_tag_reg;
  assign out_tag_valid_o = out_tag_valid_reg;
  assign serial_mode_select_o = data_format_config_reg[SERIAL_MODE_LSB +: 2];
  assign averaging_ratio_o = averaging_ratio_config_reg[AVG_LSB +: 3];
  assign average_count_o = (averaging_ratio_o == 3'h0) ? 8'h01 : (8'h01 << averaging_ratio_o);
  assign oscillator_select_o = oscillator_timing_config_reg[OSCILLATOR_SELECT_BIT];
  assign clock_divider_o = oscillator_timing_config_reg[CLK_DIV_LSB +: 4];

endmodule
`default_nettype wire

// ===== hdl/adcreg_pkg.sv
`default_nettype none
package adcreg_pkg;
  // Register address and data widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHAN_N = 8;
  localparam int unsigned CONV_W = 16;
  localparam int unsigned TAG_W = 4;
  // Register offsets
  localparam logic [7:0] DATA_FORMAT_CONFIG_ADDR = 8'h02;
  localparam logic [7:0] AVERAGING_RATIO_CONFIG_ADDR = 8'h03;
  localparam logic [7:0] OSCILLATOR_TIMING_CONFIG_ADDR = 8'h04;
  localparam logic [7:0] CHANNEL_FUNCTION_SELECT_ADDR = 8'h05;
  localparam logic [7:0] DIGITAL_PIN_DIRECTION_ADDR = 8'h07;
  localparam logic [7:0] OUTPUT_DRIVE_TYPE_ADDR = 8'h09;
  localparam logic [7:0] OUTPUT_LEVEL_ADDR = 8'h0B;
  localparam logic [7:0] INPUT_LEVEL_READBACK_ADDR = 8'h0D;
  // Reset values
  localparam logic [7:0] DATA_FORMAT_CONFIG_RST = 8'h00;
  localparam logic [7:0] AVERAGING_RATIO_CONFIG_RST = 8'h00;
  localparam logic [7:0] OSCILLATOR_TIMING_CONFIG_RST = 8'h04;
  localparam logic [7:0] PIN_CFG_RST = 8'h00;
  // Writable bit masks; other bits are reserved
  localparam logic [7:0] DATA_FORMAT_MASK = 8'hB3;
  localparam logic [7:0] AVERAGING_MASK = 8'h07;
  localparam logic [7:0] OSC_TIMING_MASK = 8'h1F;
  // Field positions
  localparam int unsigned TEST_PATTERN_BIT = 7;
  localparam int unsigned APPEND_LSB = 4;
  localparam int unsigned SERIAL_MODE_LSB = 0;
  localparam int unsigned AVG_LSB = 0;
  localparam int unsigned OSCILLATOR_SELECT_BIT = 4;
  localparam int unsigned CLK_DIV_LSB = 0;
  // Fixed test pattern word
  localparam logic [15:0] TEST_PATTERN_WORD = 16'hA5A5;
  // Append selector codes
  localparam logic [1:0] APPEND_NONE = 2'h0;
  localparam logic [1:0] APPEND_CHAN_ID = 2'h1;
  localparam logic [1:0] APPEND_STATUS = 2'h2;
endpackage
`default_nettype wire

// ===== dv/adcreg_bank_checker.sv
`default_nettype none
module adcreg_checker
(
  // Watched ports
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic soft_reset_i,
  input wire logic force_analog_channels_i,
  input wire logic [1:0] serial_mode_select_o,
  input wire logic [2:0] averaging_ratio_o,
  input wire logic [7:0] average_count_o,
  input wire logic oscillator_select_o,
  input wire logic [3:0] clock_divider_o,
  input wire logic [7:0] analog_channel_o,
  input wire logic [7:0] pin_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Count doubles per code, one sample when off
  property p_avg; average_count_o == 8'(1 << averaging_ratio_o); endproperty
  a_avg: assert property (p_avg) else $error("average count wrong");
  property p_oe; (pin_oe_o & analog_channel_o) == 8'h00; endproperty
  a_oe: assert property (p_oe) else $error("analog pin driven");
  property p_force; force_analog_channels_i |-> analog_channel_o == 8'hFF && pin_oe_o == 8'h00;
  endproperty
  a_force: assert property (p_force) else $error("force analog ignored");
  property p_fn;
    wr_en_i && addr_i == 8'h05 && !soft_reset_i
    |=> force_analog_channels_i || analog_channel_o == ~$past(wdata_i);
  endproperty
  a_fn: assert property (p_fn) else $error("channel function not applied");
  property p_osc;
    wr_en_i && addr_i == 8'h04 && !soft_reset_i
    |=> oscillator_select_o == $past(wdata_i[4]) && clock_divider_o == $past(wdata_i[3:0]);
  endproperty
  a_osc: assert property (p_osc) else $error("timing fields not applied");
  property p_soft;
    soft_reset_i |=> clock_divider_o == 4'h4 && !oscillator_select_o
    && averaging_ratio_o == 3'h0 && serial_mode_select_o == 2'h0;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset defaults wrong");
  property p_unm; rd_en_i && addr_i == 8'h01 |=> rdata_o == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hold; !rd_en_i && !soft_reset_i |=> $stable(rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_force: cover property (force_analog_channels_i && wr_en_i);
  c_soft: cover property (soft_reset_i && wr_en_i);
  c_unm: cover property (rd_en_i && addr_i == 8'h01);
endmodule
bind adcreg_bank adcreg_checker chk (.*);
`default_nettype wire

// ===== dv/adcreg_pin_world.sv
`default_nettype none
module adcreg_pin_world
(
  // Device drive and outside drive
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  // Resolved wire levels
  output logic [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // external pull-up
  // Device wins where it drives; an undriven wire floats up, as open-drain needs
  assign level_o = (pin_oe_o & pin_o) | (~pin_oe_o & (~ext_en_i | ext_val_i));
endmodule
`default_nettype wire

// ===== dv/adcreg_bank_tb.sv
`default_nettype none
module adcreg_bank_tb;
  import adcreg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, resetn_i, wr_en_i, rd_en_i, soft_reset_i, force_analog_channels_i, oscillator_select_o;
  logic rd_q = 1'b0;
  logic [7:0] addr_i, wdata_i, rdata_o, pin_i, pin_o, pin_oe_o, analog_channel_o, average_count_o;
  logic [7:0] ext_en, ext_val, f, d, t, l;
  logic [15:0] conv_data_i, out_data_o;
  logic [3:0] manual_channel_number_i, status_flags_i, out_tag_o, clock_divider_o, g;
  logic [2:0] averaging_ratio_o;
  logic [1:0] serial_mode_select_o;
  logic out_tag_valid_o;
  logic [7:0] exp_q[$];
  logic [7:0] ra[7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0B};
  int num_errors = 0;
  int n_compared = 0;
  adcreg_bank uut (.*);
  adcreg_pin_world pins (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(pin_i));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock_i);
    wr_en_i = 1'b1;
    addr_i = a;
    wdata_i = v;
    @(negedge clock_i);
    wr_en_i = 1'b0;
  endtask
  // Read notes its expectation; the watcher below compares it
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge clock_i);
    rd_en_i = 1'b1;
    addr_i = a;
    exp_q.push_back(x);
    @(negedge clock_i);
    rd_en_i = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Clock, 20 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Read data lands one edge after the strobe
  always @(posedge clock_i) rd_q <= rd_en_i;
  always @(negedge clock_i) if (rd_q === 1'b1) chk("rdata", rdata_o, exp_q.pop_front());
  // Watchdog well past the expected few microseconds
  initial
  begin
    #50us;
    num_errors++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {wr_en_i, rd_en_i, soft_reset_i, force_analog_channels_i, resetn_i} = 5'h00;
    {addr_i, wdata_i, ext_en, ext_val} = 32'h0;
    {conv_data_i, manual_channel_number_i, status_flags_i} = 24'h0;
    void'($urandom(32'h477D6797));
    repeat (8) @(negedge clock_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], (i == 2) ? 8'h04 : 8'h00);
    wr(8'h02, 8'hFF);
    wr(8'h03, 8'hFF);
    wr(8'h04, 8'hFF);
    rd(8'h02, 8'hB3);
    rd(8'h03, 8'h07);
    rd(8'h04, 8'h1F);
    chk("osc", 16'(oscillator_select_o), 16'h1);
    chk("div", 16'(clock_divider_o), 16'hF);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h03, 8'(i));
      chk("avg", 16'(average_count_o), 16'(1 << i));
      chk("ratio", 16'(averaging_ratio_o), 16'(i));
    end
    // Pattern, append codes including the reserved one, all serial modes
    // every channel is still analog here, so any channel number is legal
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h02, {m[2], 1'b0, m[1:0], 2'b00, ~m[1:0]});
      conv_data_i = 16'($urandom);
      {manual_channel_number_i, status_flags_i} = 8'($urandom);
      g = (m[1:0] == 2'h1) ? manual_channel_number_i : (m[1:0] == 2'h2) ? status_flags_i : 4'h0;
      @(negedge clock_i);
      chk("mode", 16'(serial_mode_select_o), {14'h0000, ~m[1:0]});
      chk("data", out_data_o, m[2] ? 16'hA5A5 : conv_data_i);
      chk("tag", 16'(out_tag_o), 16'(g));
      chk("tagv", 16'(out_tag_valid_o), 16'(g != 4'h0 || m[1:0] == 2'h1 || m[1:0] == 2'h2));
    end
    // Random pin setups, last one under force-analog
    for (int k = 0; k < 6; k++)
    begin
      {f, d, t, l} = $urandom;
      force_analog_channels_i = (k == 5);
      wr(8'h05, f);
      wr(8'h07, d);
      wr(8'h09, t);
      wr(8'h0B, l);
      chk("oe", 16'(pin_oe_o), (k == 5) ? 16'h0 : 16'(f & d & (t | ~l)));
      chk("pin", 16'(pin_o), 16'(l));
      chk("ana", 16'(analog_channel_o), (k == 5) ? 16'h00FF : {8'h00, ~f});
    end
    force_analog_channels_i = 1'b0;
    wr(8'h05, 8'h00);
    ext_en = 8'hFF;
    ext_val = 8'($urandom);
    repeat (3) @(negedge clock_i);
    rd(8'h0D, ext_val);
    wr(8'h0D, ~ext_val);
    rd(8'h0D, ext_val);
    rd(8'h01, 8'h00);
    rd(8'h0E, 8'h00);
    // Soft reset beats a write in the same cycle
    @(negedge clock_i);
    {soft_reset_i, wr_en_i, addr_i, wdata_i} = {2'b11, 8'h04, 8'h13};
    @(negedge clock_i);
    {soft_reset_i, wr_en_i} = 2'b00;
    rd(8'h04, 8'h04);
    rd(8'h02, 8'h00);
    @(negedge clock_i);
    report_and_stop();
  end
endmodule
`default_nettype wire
